// [dv/dsle_chk.sv]
// concurrent checks on the ports of the lamp encoder top
// assumes a bind into dsle_top, one clock, synchronous active high reset
`timescale 1ns/1ps
module dsle_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic busy_led_o,
    input wire logic clean_led_o,
    input wire logic maint_led_o,
    input wire logic drive_inhibit_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------------------------------
    // helpers: cycles since the last control write and irq clearing access
    // ----------------------------------------------------------------
    logic wr_now, clr_now;
    logic [3:0] wr_age_q, wr_age_d, clr_age_q, clr_age_d;
    always_comb begin
        wr_now = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == dsle_pkg::ADDR_CTRL;
        clr_now = wb_ack_o && wb_cyc_i && wb_stb_i &&
            (wb_adr_i == dsle_pkg::ADDR_ISTAT || wb_adr_i == dsle_pkg::ADDR_IMASK);
        wr_age_d = wr_now ? 4'h0 : (wr_age_q == 4'hf ? wr_age_q : wr_age_q + 4'h1);
        clr_age_d = clr_now ? 4'h0 : (clr_age_q == 4'hf ? clr_age_q : clr_age_q + 4'h1);
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_age_q <= 4'hf;
            clr_age_q <= 4'hf;
        end else begin
            wr_age_q <= wr_age_d;
            clr_age_q <= clr_age_d;
        end
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not acknowledged next cycle");
    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack cycle");
    property p_rel_quiet;
        $fell(rst_i) |-> !busy_led_o && !clean_led_o && !maint_led_o && !irq_o;
    endproperty
    a_rel_quiet: assert property (p_rel_quiet) else $error("outputs not quiet after reset");
    property p_lamp_test;
        $fell(rst_i) |=> (busy_led_o && clean_led_o && maint_led_o) [*8];
    endproperty
    a_lamp_test: assert property (p_lamp_test) else $error("no lamp test after reset");
    property p_hard_flash;
        wr_now && wb_dat_i[8] && !wb_dat_i[9] |->
            ##4 (busy_led_o == clean_led_o && clean_led_o == maint_led_o) [*8];
    endproperty
    a_hard_flash: assert property (p_hard_flash) else $error("hard fail lamps not in step");
    property p_rec_test;
        wr_now && wb_dat_i[9] |-> ##[1:3] (busy_led_o && clean_led_o && maint_led_o) [*8];
    endproperty
    a_rec_test: assert property (p_rec_test) else $error("no lamp test at recovery");
    property p_irq_clear;
        $fell(irq_o) |-> clr_now || clr_age_q <= 4'h3;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq fell without clearing access");
    property p_inhibit_cause;
        $changed(drive_inhibit_o) |-> wr_now || wr_age_q <= 4'h3;
    endproperty
    a_inhibit_cause: assert property (p_inhibit_cause) else $error("inhibit moved on its own");
endmodule

// [dv/dsle_lamp_view.sv]
// operator view of the three lamps: classes each as off, on or flashing
// assumes clr_i restarts the viewing window; window shorter than 256 cycles
`timescale 1ns/1ps
module dsle_lamp_view (
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic [2:0] lamp_i,
    output logic [5:0] cls_o
);
    logic [7:0] tot_q;
    logic [7:0] on_q [3];
    always_ff @(posedge clk_i) begin
        tot_q <= clr_i ? 8'h00 : tot_q + 8'h01;
        for (int i = 0; i < 3; i++) begin
            on_q[i] <= clr_i ? 8'h00 : on_q[i] + 8'(lamp_i[i]);
        end
    end
    // 0 off, 1 steady on, 2 flashing
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            cls_o[2*i +: 2] = on_q[i] == 8'h00 ? 2'h0 : (on_q[i] == tot_q ? 2'h1 : 2'h2);
        end
    end
endmodule

// [dv/test_drive_status_led_encoder.sv]
// self-checking bench for the drive status lamp encoder
// assumes package, blink interface and design files are compiled first
`timescale 1ns/1ps
module test_drive_status_led_encoder;
    logic clk_i, rst_i, cyc, stb, we, vclr, ack, busy, clean, maint, inhibit, irq;
    logic [7:0] adr;
    logic [3:0] sel, wsel;
    logic [31:0] dat, rdat, rd_o;
    logic [5:0] cls;
    int n_errors, compares, cycles;
    logic [10:0] tv [8] = '{11'h001, 11'h004, 11'h008, 11'h040, 11'h000, 11'h010, 11'h020, 11'h080};
    logic [6:0] te [8] = '{7'h02, 7'h08, 7'h44, 7'h60, 7'h00, 7'h10, 7'h20, 7'h14};
    dsle_top #(.LAMP_CYC(16), .QFLASH_CYC(16), .HOLD_CYC(16), .DIAG_CYC(16),
        .SLOW_BITS(6), .FAST_BITS(3)) dsle_top_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rd_o), .wb_ack_o(ack), .busy_led_o(busy),
        .clean_led_o(clean), .maint_led_o(maint), .drive_inhibit_o(inhibit), .irq_o(irq));
    dsle_lamp_view dsle_lamp_view_inst (.clk_i(clk_i), .clr_i(vclr),
        .lamp_i({busy, clean, maint}), .cls_o(cls));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic results;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t word got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_lamp(input logic [6:0] got, input logic [6:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t lamps got %h expected %h", $time, got, exp);
        end
    endtask
    // waits for ack with no limit of its own; the cycle ceiling ends a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= wsel;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rdat = rd_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk_word(rdat & m, e);
    endtask
    task automatic observe;
        @(posedge clk_i);
        vclr <= 1'b1;
        @(posedge clk_i);
        vclr <= 1'b0;
        repeat (130) @(posedge clk_i);
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            results;
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_i, vclr} = 2'b11;
        {cyc, stb, we} = 3'b000;
        adr = 8'h00;
        dat = 32'h0;
        sel = 4'hf;
        wsel = 4'hf;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (60) @(posedge clk_i);
        rd(dsle_pkg::ADDR_ISTAT, 32'hffff_ffff, 32'h8);
        rd(dsle_pkg::ADDR_IMASK, 32'hffff_ffff, 32'h0);
        rd(dsle_pkg::ADDR_FAULT, 32'hffff_ffff, 32'h0);
        wb(1'b1, dsle_pkg::ADDR_FAULT, 32'h9c);
        rd(dsle_pkg::ADDR_FAULT, 32'hffff_ffff, 32'h9c);
        // byte lane 0 disabled: the fault code must keep its value
        wsel = 4'he;
        wb(1'b1, dsle_pkg::ADDR_FAULT, 32'h55);
        wsel = 4'hf;
        rd(dsle_pkg::ADDR_FAULT, 32'hffff_ffff, 32'h9c);
        wb(1'b1, 8'h14, 32'hffff_ffff);
        rd(8'h14, 32'hffff_ffff, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, dsle_pkg::ADDR_CTRL, {21'h0, tv[i]});
            observe();
            chk_lamp({inhibit, cls}, te[i]);
        end
        chk_word({31'h0, irq}, 32'h0);
        wb(1'b1, dsle_pkg::ADDR_IMASK, 32'h1f);
        repeat (3) @(posedge clk_i);
        chk_word({31'h0, irq}, 32'h1);
        rd(dsle_pkg::ADDR_ISTAT, 32'hffff_ffff, 32'h14);
        repeat (3) @(posedge clk_i);
        chk_word({31'h0, irq}, 32'h0);
        wb(1'b1, dsle_pkg::ADDR_CTRL, 32'h2);
        rd(dsle_pkg::ADDR_STATUS, 32'h400, 32'h400);
        rd(dsle_pkg::ADDR_CTRL, 32'hffff_ffff, 32'h0);
        repeat (30) @(posedge clk_i);
        rd(dsle_pkg::ADDR_ISTAT, 32'hffff_ffff, 32'h8);
        wb(1'b1, dsle_pkg::ADDR_CTRL, 32'h100);
        repeat (22) @(posedge clk_i);
        observe();
        chk_lamp({1'b0, cls} & 7'h03, 7'h01);
        rd(dsle_pkg::ADDR_ISTAT, 32'h3, 32'h1);
        wb(1'b1, dsle_pkg::ADDR_CTRL, 32'h0);
        repeat (10) @(posedge clk_i);
        wb(1'b1, dsle_pkg::ADDR_CTRL, 32'h600);
        repeat (80) @(posedge clk_i);
        rd(dsle_pkg::ADDR_STATUS, 32'h38, 32'h08);
        wb(1'b1, dsle_pkg::ADDR_CTRL, 32'h200);
        repeat (230) @(posedge clk_i);
        rd(dsle_pkg::ADDR_STATUS, 32'h1f8, 32'h138);
        observe();
        chk_lamp({1'b0, cls}, 7'h2a);
        rd(dsle_pkg::ADDR_ISTAT, 32'h3, 32'h2);
        wb(1'b1, dsle_pkg::ADDR_CTRL, 32'h400);
        repeat (80) @(posedge clk_i);
        rd(dsle_pkg::ADDR_STATUS, 32'h38, 32'h38);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd(dsle_pkg::ADDR_STATUS, 32'h38, 32'h0);
        results();
    end
endmodule
bind dsle_top dsle_chk dsle_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_led_o(busy_led_o),
    .clean_led_o(clean_led_o), .maint_led_o(maint_led_o),
    .drive_inhibit_o(drive_inhibit_o), .irq_o(irq_o));

// [include/dsle_blink_if.sv]
// shared blink phases between the divider and the lamp encoder
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface dsle_blink_if;
    logic slow_ph;
    logic fast_ph;
    logic slow_wrap;
    modport src (output slow_ph, output fast_ph, output slow_wrap);
    modport snk (input slow_ph, input fast_ph, input slow_wrap);
endinterface

// [include/dsle_pkg.sv]
// constants and types of the drive status lamp encoder
// assumes a 40 MHz system clock and a 32-bit classic wishbone register port
package dsle_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_KHZ = 40000;
    localparam int unsigned LAMP_MS = 1000;
    localparam int unsigned QFLASH_MS = 1000;
    localparam int unsigned HOLD_MS = 2000;
    localparam int unsigned DIAG_MS = 2000;
    localparam int unsigned LAMP_CYC = LAMP_MS * CLK_KHZ;
    localparam int unsigned QFLASH_CYC = QFLASH_MS * CLK_KHZ;
    localparam int unsigned HOLD_CYC = HOLD_MS * CLK_KHZ;
    localparam int unsigned DIAG_CYC = DIAG_MS * CLK_KHZ;
    // blink divider: slow phase toggles every 2**(SLOW_BITS-1) cycles
    localparam int unsigned SLOW_BITS = 24;
    localparam int unsigned FAST_BITS = 21;
    localparam logic [2:0] REC_MAX = 3'h4;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FAULT = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_ISTAT = 8'h0c;
    localparam logic [7:0] ADDR_IMASK = 8'h10;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [7:0] FAULT_RST = 8'h00;
    localparam logic [4:0] IMASK_RST = 5'h00;

    // control bit positions
    localparam int unsigned C_SELF_CHECK = 0;
    localparam int unsigned C_DIAG_CMD = 1;
    localparam int unsigned C_CLEAN_ADV = 2;
    localparam int unsigned C_CLEAN_ENF = 3;
    localparam int unsigned C_MOTION = 4;
    localparam int unsigned C_UNLOAD = 5;
    localparam int unsigned C_CART = 6;
    localparam int unsigned C_ATTN = 7;
    localparam int unsigned C_HARD_FAIL = 8;
    localparam int unsigned C_REC_START = 9;
    localparam int unsigned C_REC_OK = 10;
    localparam int unsigned CTRL_BITS = 11;

    // interrupt status bit positions
    localparam int unsigned I_FAIL = 0;
    localparam int unsigned I_DEAD = 1;
    localparam int unsigned I_ATTN = 2;
    localparam int unsigned I_DIAG = 3;
    localparam int unsigned I_ENF = 4;
    localparam int unsigned IRQ_BITS = 5;

    typedef enum logic [2:0] {
        ST_LAMP, ST_RUN, ST_FFLASH, ST_FCODE, ST_RFLASH1, ST_RHOLD, ST_RFLASH2, ST_RDEAD
    } dsle_state_t;

endpackage

// [logic/dsle_blink.sv]
// one free running divider giving the slow and quick blink phases
// assumes synchronous active high reset on clk_i
`timescale 1ns/1ps
module dsle_blink #(
    parameter int unsigned SLOW_BITS = dsle_pkg::SLOW_BITS,
    parameter int unsigned FAST_BITS = dsle_pkg::FAST_BITS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    dsle_blink_if.src bl
);
    if (FAST_BITS < 2 || FAST_BITS >= SLOW_BITS || SLOW_BITS > 31) begin : g_bad
        $error("dsle_blink: need 2 <= FAST_BITS < SLOW_BITS <= 31");
    end

    logic [SLOW_BITS-1:0] cnt_q;
    logic [SLOW_BITS-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q + {{(SLOW_BITS-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // both phases come from one counter so all flashing lamps stay in step
    assign bl.slow_ph = cnt_q[SLOW_BITS-1];
    assign bl.fast_ph = cnt_q[FAST_BITS-1];
    assign bl.slow_wrap = &cnt_q;
endmodule

// [logic/dsle_top.sv]
// drive status lamp encoder: busy, clean and maintenance indicators
// assumes classic wishbone master on clk_i, synchronous active high reset
`timescale 1ns/1ps

module dsle_top #(
    parameter int unsigned LAMP_CYC = dsle_pkg::LAMP_CYC,
    parameter int unsigned QFLASH_CYC = dsle_pkg::QFLASH_CYC,
    parameter int unsigned HOLD_CYC = dsle_pkg::HOLD_CYC,
    parameter int unsigned DIAG_CYC = dsle_pkg::DIAG_CYC,
    parameter int unsigned SLOW_BITS = dsle_pkg::SLOW_BITS,
    parameter int unsigned FAST_BITS = dsle_pkg::FAST_BITS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic busy_led_o,
    output logic clean_led_o,
    output logic maint_led_o,
    output logic drive_inhibit_o,
    output logic irq_o
);
    if (LAMP_CYC == 0 || QFLASH_CYC == 0 || HOLD_CYC == 0 || DIAG_CYC == 0) begin : g_bad
        $error("dsle_top: every interval must be at least one cycle");
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] tick(input logic [31:0] t);
        return (t > 32'h1) ? t - 32'h1 : 32'h0;
    endfunction

    // ----------------------------------------------------------------
    // blink source
    // ----------------------------------------------------------------
    dsle_blink_if bl ();

    dsle_blink #(
        .SLOW_BITS(SLOW_BITS),
        .FAST_BITS(FAST_BITS)
    ) u_blink (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bl(bl)
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [dsle_pkg::CTRL_BITS-1:0] ctrl_q, ctrl_d;
    logic [7:0] fault_q, fault_d;
    logic [dsle_pkg::IRQ_BITS-1:0] istat_q, istat_d, imask_q, imask_d, ev;
    logic [31:0] dat_q, dat_d;
    logic ack_q, ack_d, irq_q, irq_d;
    dsle_pkg::dsle_state_t st_q, st_d;
    logic [31:0] tmr_q, tmr_d, diag_q, diag_d;
    logic [2:0] att_q, att_d;
    logic [1:0] idx_q, idx_d;
    logic rec_q, rec_d, enf_q, enf_d, cart_q, attn_q;
    logic busy_q, busy_d, clean_q, clean_d, maint_q, maint_d;
    logic acc, wr, rd, done, diag_on;
    logic [31:0] ctrl_w;

    assign done = (tmr_q <= 32'h1);
    assign diag_on = (diag_q != 32'h0) | ctrl_q[dsle_pkg::C_SELF_CHECK];

    // ----------------------------------------------------------------
    // wishbone slave and interrupt registers
    // ----------------------------------------------------------------
    always_comb begin
        acc = wb_cyc_i & wb_stb_i & ~ack_q;
        wr = acc & wb_we_i;
        rd = acc & ~wb_we_i;
        ctrl_w = wmerge({{(32-dsle_pkg::CTRL_BITS){1'b0}}, ctrl_q}, wb_dat_i, wb_sel_i);
        ctrl_d = ctrl_q;
        // command bits last one cycle
        ctrl_d[dsle_pkg::C_DIAG_CMD] = 1'b0;
        ctrl_d[dsle_pkg::C_REC_START] = 1'b0;
        fault_d = fault_q;
        imask_d = imask_q;
        istat_d = istat_q;
        dat_d = 32'h0;
        if (wr && wb_adr_i == dsle_pkg::ADDR_CTRL) begin
            ctrl_d = ctrl_w[dsle_pkg::CTRL_BITS-1:0];
        end
        if (wr && wb_adr_i == dsle_pkg::ADDR_FAULT && wb_sel_i[0]) begin
            fault_d = wb_dat_i[7:0];
        end
        if (wr && wb_adr_i == dsle_pkg::ADDR_IMASK && wb_sel_i[0]) begin
            imask_d = wb_dat_i[dsle_pkg::IRQ_BITS-1:0];
        end
        if (rd) begin
            case (wb_adr_i)
                dsle_pkg::ADDR_CTRL: dat_d = {{(32-dsle_pkg::CTRL_BITS){1'b0}}, ctrl_q};
                dsle_pkg::ADDR_FAULT: dat_d = {24'h0, fault_q};
                dsle_pkg::ADDR_STATUS: begin
                    dat_d = {21'h0, diag_on, enf_q, att_q, st_q, busy_q, clean_q, maint_q};
                end
                dsle_pkg::ADDR_ISTAT: begin
                    dat_d = {{(32-dsle_pkg::IRQ_BITS){1'b0}}, istat_q};
                    istat_d = '0;
                end
                dsle_pkg::ADDR_IMASK: dat_d = {{(32-dsle_pkg::IRQ_BITS){1'b0}}, imask_q};
                default: dat_d = 32'h0;
            endcase
        end
        // a new event wins over the clearing read
        istat_d = istat_d | ev;
        ack_d = acc;
        irq_d = |(istat_q & imask_q);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= dsle_pkg::CTRL_RST[dsle_pkg::CTRL_BITS-1:0];
            fault_q <= dsle_pkg::FAULT_RST;
            imask_q <= dsle_pkg::IMASK_RST;
            istat_q <= '0;
            dat_q <= 32'h0;
            ack_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            fault_q <= fault_d;
            imask_q <= imask_d;
            istat_q <= istat_d;
            dat_q <= dat_d;
            ack_q <= ack_d;
            irq_q <= irq_d;
        end
    end

    // ----------------------------------------------------------------
    // lamp sequencer
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        tmr_d = tick(tmr_q);
        diag_d = tick(diag_q);
        att_d = att_q;
        rec_d = rec_q;
        idx_d = bl.slow_wrap ? idx_q + 2'h1 : idx_q;
        ev = '0;
        // enforced cleaning holds until the cleaning cartridge leaves
        enf_d = (enf_q & ~(cart_q & ~ctrl_q[dsle_pkg::C_CART])) | ctrl_q[dsle_pkg::C_CLEAN_ENF];
        ev[dsle_pkg::I_ENF] = ctrl_q[dsle_pkg::C_CLEAN_ENF] & ~enf_q;
        ev[dsle_pkg::I_ATTN] = ctrl_q[dsle_pkg::C_ATTN] & ~attn_q;
        ev[dsle_pkg::I_DIAG] = (diag_q == 32'h1);
        if (ctrl_q[dsle_pkg::C_DIAG_CMD]) begin
            diag_d = DIAG_CYC;
        end
        busy_d = 1'b0;
        clean_d = 1'b0;
        maint_d = 1'b0;
        case (st_q)
            dsle_pkg::ST_LAMP: begin
                {busy_d, clean_d, maint_d} = 3'h7;
                if (done) begin
                    tmr_d = QFLASH_CYC;
                    if (rec_q) begin
                        st_d = dsle_pkg::ST_RFLASH1;
                    end else begin
                        st_d = dsle_pkg::ST_RUN;
                        diag_d = DIAG_CYC;
                    end
                end
            end
            dsle_pkg::ST_RUN: begin
                if (diag_on) begin
                    maint_d = bl.slow_ph;
                end else if (ctrl_q[dsle_pkg::C_CART]) begin
                    busy_d = bl.slow_ph;
                end else if (enf_q) begin
                    clean_d = 1'b1;
                end else if (ctrl_q[dsle_pkg::C_ATTN]) begin
                    {busy_d, clean_d} = 2'h3;
                end else if (ctrl_q[dsle_pkg::C_MOTION]) begin
                    busy_d = 1'b1;
                end else if (ctrl_q[dsle_pkg::C_UNLOAD]) begin
                    busy_d = bl.slow_ph;
                end else if (ctrl_q[dsle_pkg::C_CLEAN_ADV]) begin
                    clean_d = bl.slow_ph;
                end
                if (ctrl_q[dsle_pkg::C_HARD_FAIL]) begin
                    st_d = dsle_pkg::ST_FFLASH;
                    tmr_d = QFLASH_CYC;
                    ev[dsle_pkg::I_FAIL] = 1'b1;
                end
            end
            dsle_pkg::ST_FFLASH: begin
                {busy_d, clean_d, maint_d} = {3{bl.fast_ph}};
                if (done) begin
                    st_d = dsle_pkg::ST_FCODE;
                    idx_d = 2'h0;
                end
            end
            dsle_pkg::ST_FCODE: begin
                // two code bits per slow period, high pair first
                maint_d = 1'b1;
                busy_d = fault_q[{~idx_q, 1'b1}] & bl.slow_ph;
                clean_d = fault_q[{~idx_q, 1'b0}] & bl.slow_ph;
                if (!ctrl_q[dsle_pkg::C_HARD_FAIL]) begin
                    st_d = dsle_pkg::ST_RUN;
                end
            end
            dsle_pkg::ST_RFLASH1, dsle_pkg::ST_RFLASH2: begin
                {busy_d, clean_d, maint_d} = {3{bl.fast_ph}};
                if (done && st_q == dsle_pkg::ST_RFLASH1) begin
                    st_d = dsle_pkg::ST_RHOLD;
                    tmr_d = HOLD_CYC;
                end else if (done) begin
                    att_d = att_q + 3'h1;
                    tmr_d = QFLASH_CYC;
                    if (ctrl_q[dsle_pkg::C_REC_OK]) begin
                        st_d = dsle_pkg::ST_RUN;
                        rec_d = 1'b0;
                    end else if (att_q + 3'h1 >= dsle_pkg::REC_MAX) begin
                        st_d = dsle_pkg::ST_RDEAD;
                        ev[dsle_pkg::I_DEAD] = 1'b1;
                    end else begin
                        st_d = dsle_pkg::ST_RFLASH1;
                    end
                end
            end
            dsle_pkg::ST_RHOLD: begin
                {busy_d, clean_d, maint_d} = 3'h7;
                if (done) begin
                    st_d = dsle_pkg::ST_RFLASH2;
                    tmr_d = QFLASH_CYC;
                end
            end
            dsle_pkg::ST_RDEAD: begin
                {busy_d, clean_d, maint_d} = {3{bl.fast_ph}};
            end
            default: begin
                st_d = dsle_pkg::ST_RUN;
            end
        endcase
        // recovery start restarts with the lamp test; only reset leaves a dead drive
        if (ctrl_q[dsle_pkg::C_REC_START] && st_q != dsle_pkg::ST_RDEAD) begin
            st_d = dsle_pkg::ST_LAMP;
            tmr_d = LAMP_CYC;
            rec_d = 1'b1;
            att_d = 3'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= dsle_pkg::ST_LAMP;
            tmr_q <= LAMP_CYC;
            diag_q <= 32'h0;
            att_q <= 3'h0;
            rec_q <= 1'b0;
            idx_q <= 2'h0;
            enf_q <= 1'b0;
            cart_q <= 1'b0;
            attn_q <= 1'b0;
            busy_q <= 1'b0;
            clean_q <= 1'b0;
            maint_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            diag_q <= diag_d;
            att_q <= att_d;
            rec_q <= rec_d;
            idx_q <= idx_d;
            enf_q <= enf_d;
            cart_q <= ctrl_q[dsle_pkg::C_CART];
            attn_q <= ctrl_q[dsle_pkg::C_ATTN];
            busy_q <= busy_d;
            clean_q <= clean_d;
            maint_q <= maint_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign irq_o = irq_q;
    assign busy_led_o = busy_q;
    assign clean_led_o = clean_q;
    assign maint_led_o = maint_q;
    assign drive_inhibit_o = enf_q;
endmodule
